// >>> logic/aid_map.vh
`ifndef AID_MAP_VH
`define AID_MAP_VH

// Register byte offsets
`define AID_OFF_INSTR   8'h00
`define AID_OFF_PC      8'h04
`define AID_OFF_CTRL    8'h08
`define AID_OFF_CMD     8'h0C
`define AID_OFF_FLAGS   8'h10
`define AID_OFF_STATUS  8'h14
`define AID_OFF_RESULT  8'h18
`define AID_OFF_TARGET  8'h1C
// General registers r0..r15 at 8'h40 + 4*index
`define AID_RF_BASE_HI  2'h1

// CTRL bit positions
`define AID_CTRL_MAIN   0
`define AID_CTRL_INBLK  1
`define AID_CTRL_LAST   2
`define AID_CTRL_PASS   3
`define AID_CTRL_WIDE   4
`define AID_CTRL_RESET  5'h09

// CMD bit position
`define AID_CMD_GO      0

// FLAGS bit positions
`define AID_FLAG_V      0
`define AID_FLAG_C      1
`define AID_FLAG_Z      2
`define AID_FLAG_N      3

// STATUS bit positions
`define AID_ST_DONE     0
`define AID_ST_EXEC     1
`define AID_ST_UNDEF    2
`define AID_ST_UNPRED   3
`define AID_ST_REDIR    4
`define AID_ST_BRANCH   5
`define AID_ST_UNKNOWN  6
`define AID_ST_CODE_LO  8

// Redirect codes
`define AID_RD_NONE     3'h0
`define AID_RD_SP_REG   3'h1
`define AID_RD_SP_IMM   3'h2
`define AID_RD_CMN_REG  3'h3
`define AID_RD_CMN_IMM  3'h4

// Shift kinds
`define AID_SH_LSL      2'h0
`define AID_SH_LSR      2'h1
`define AID_SH_ASR      2'h2
`define AID_SH_ROR      2'h3
`define AID_SH_RRX      3'h4

// Register indices of note
`define AID_R_SP        4'hD
`define AID_R_PC        4'hF

`endif

// >>> logic/aid_add_exec.v
// Local design decisions: the register addresses and the APB register port.
`include "aid_map.vh"

module aid_add_exec (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_b,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Branch request toward fetch
  output reg         branch_valid_q,
  output reg  [31:0] branch_addr_q
);

  reg  [31:0] instr_q;
  reg  [31:0] pc_q;
  reg  [4:0]  ctrl_q;
  reg  [3:0]  flags_q;
  reg  [31:0] status_q;
  reg  [31:0] result_q;
  reg         go_q;
  reg  [31:0] rf_q [0:15];

  wire [15:0] hw1 = instr_q[31:16];
  wire [15:0] hw2 = instr_q[15:0];
  wire        main_ext = ctrl_q[`AID_CTRL_MAIN];
  wire        in_blk   = ctrl_q[`AID_CTRL_INBLK];
  wire        last_blk = ctrl_q[`AID_CTRL_LAST];
  wire        cond_ok  = ctrl_q[`AID_CTRL_PASS];
  wire        wide     = ctrl_q[`AID_CTRL_WIDE];
  wire [11:0] twelve_bit_immediate = {hw1[10], hw2[14:12], hw2[7:0]};
  wire [4:0]  amount_fields = {hw2[14:12], hw2[7:6]};

  // Modified-immediate constant expansion; bit 32 marks a bad encoding
  function [32:0] expand_imm;
    input [11:0] v;
    reg   [31:0] unrot;
    reg   [4:0]  rot;
    begin
      unrot = {24'h000000, 1'b1, v[6:0]};
      rot   = v[11:7];
      if (v[11:10] == 2'h0) begin
        case (v[9:8])
          2'h0: expand_imm = {1'b0, 24'h000000, v[7:0]};
          2'h1: expand_imm = {v[7:0] == 8'h00, 8'h00, v[7:0], 8'h00,
                              v[7:0]};
          2'h2: expand_imm = {v[7:0] == 8'h00, v[7:0], 8'h00, v[7:0],
                              8'h00};
          default: expand_imm = {v[7:0] == 8'h00, {4{v[7:0]}}};
        endcase
      end else begin
        expand_imm = {1'b0, (unrot >> rot) | (unrot << (6'd32 - {1'b0, rot}))};
      end
    end
  endfunction

  // Shifter; kind uses 3 bits so the carry rotate is its own case
  function [31:0] shift_val;
    input [31:0] v;
    input [2:0]  kind;
    input [5:0]  amt;
    input        cin;
    begin
      case (kind)
        {1'b0, `AID_SH_LSL}: shift_val = v << amt;
        {1'b0, `AID_SH_LSR}: shift_val = v >> amt;
        {1'b0, `AID_SH_ASR}: shift_val = $signed(v) >>> amt;
        {1'b0, `AID_SH_ROR}: shift_val = (v >> amt) | (v << (6'd32 - amt));
        `AID_SH_RRX:         shift_val = {cin, v[31:1]};
        default:             shift_val = v;
      endcase
    end
  endfunction

  // Register 15 is the program counter wherever it is read as a source
  function [31:0] src_val;
    input [3:0]  idx;
    input [31:0] gpr;
    input [31:0] pc;
    begin
      if (idx == `AID_R_PC)
        src_val = pc;
      else
        src_val = gpr;
    end
  endfunction

  // Decode results
  reg         known;
  reg         undef;
  reg         unpred;
  reg  [2:0]  redir;
  reg         setflags;
  reg         use_pc;
  reg         use_imm;
  reg         is_branch;
  reg  [3:0]  d_idx;
  reg  [3:0]  n_idx;
  reg  [3:0]  m_idx;
  reg  [31:0] imm32;
  reg  [2:0]  sh_kind;
  reg  [5:0]  sh_amt;
  reg  [32:0] exp_imm;

  always @* begin
    known     = 1'b0;
    undef     = 1'b0;
    unpred    = 1'b0;
    redir     = `AID_RD_NONE;
    setflags  = 1'b0;
    use_pc    = 1'b0;
    use_imm   = 1'b1;
    is_branch = 1'b0;
    d_idx     = 4'h0;
    n_idx     = 4'h0;
    m_idx     = 4'h0;
    imm32     = 32'h00000000;
    sh_kind   = {1'b0, `AID_SH_LSL};
    sh_amt    = 6'h00;
    exp_imm   = expand_imm(twelve_bit_immediate);
    if (!wide) begin
      if (hw2[15:9] == 7'h0E) begin
        known    = 1'b1;
        d_idx    = {1'b0, hw2[2:0]};
        n_idx    = {1'b0, hw2[5:3]};
        imm32    = {29'h00000000, hw2[8:6]};
        setflags = !in_blk;
      end else if (hw2[15:11] == 5'h06) begin
        known    = 1'b1;
        d_idx    = {1'b0, hw2[10:8]};
        n_idx    = {1'b0, hw2[10:8]};
        imm32    = {24'h000000, hw2[7:0]};
        setflags = !in_blk;
      end else if (hw2[15:9] == 7'h0C) begin
        known    = 1'b1;
        use_imm  = 1'b0;
        d_idx    = {1'b0, hw2[2:0]};
        n_idx    = {1'b0, hw2[5:3]};
        m_idx    = {1'b0, hw2[8:6]};
        setflags = !in_blk;
      end else if (hw2[15:8] == 8'h44) begin
        known    = 1'b1;
        use_imm  = 1'b0;
        d_idx    = {hw2[7], hw2[2:0]};
        n_idx    = {hw2[7], hw2[2:0]};
        m_idx    = hw2[6:3];
        if (d_idx == `AID_R_SP || m_idx == `AID_R_SP)
          redir = `AID_RD_SP_REG;
        if (n_idx == `AID_R_PC && m_idx == `AID_R_PC)
          unpred = 1'b1;
        if (d_idx == `AID_R_PC && in_blk && !last_blk)
          unpred = 1'b1;
        is_branch = (d_idx == `AID_R_PC);
      end else if (hw2[15:11] == 5'h14) begin
        known  = 1'b1;
        use_pc = 1'b1;
        d_idx  = {1'b0, hw2[10:8]};
        imm32  = {22'h000000, hw2[7:0], 2'h0};
      end
    end else if (!hw2[15]) begin
      if (hw1[15:11] == 5'h1E && hw1[9:5] == 5'h08) begin
        known    = 1'b1;
        d_idx    = hw2[11:8];
        n_idx    = hw1[3:0];
        setflags = hw1[4];
        imm32    = exp_imm[31:0];
        if (d_idx == `AID_R_PC && hw1[4])
          redir = `AID_RD_CMN_IMM;
        else if (n_idx == `AID_R_SP)
          redir = `AID_RD_SP_IMM;
        else if (!main_ext)
          undef = 1'b1;
        else if (d_idx == `AID_R_SP || (d_idx == `AID_R_PC && !hw1[4]) ||
                 n_idx == `AID_R_PC || exp_imm[32])
          unpred = 1'b1;
      end else if (hw1[15:11] == 5'h1E && hw1[9:4] == 6'h20) begin
        known  = 1'b1;
        d_idx  = hw2[11:8];
        n_idx  = hw1[3:0];
        use_pc = (hw1[3:0] == `AID_R_PC);
        imm32  = {20'h00000, twelve_bit_immediate};
        if (n_idx == `AID_R_SP)
          redir = `AID_RD_SP_IMM;
        else if (!main_ext)
          undef = 1'b1;
        else if (d_idx == `AID_R_SP || d_idx == `AID_R_PC)
          unpred = 1'b1;
      end else if (hw1[15:5] == 11'h758) begin
        known    = 1'b1;
        use_imm  = 1'b0;
        d_idx    = hw2[11:8];
        n_idx    = hw1[3:0];
        m_idx    = hw2[3:0];
        setflags = hw1[4];
        case (hw2[5:4])
          `AID_SH_LSL: begin
            sh_kind = {1'b0, `AID_SH_LSL};
            sh_amt  = {1'b0, amount_fields};
          end
          `AID_SH_LSR: begin
            sh_kind = {1'b0, `AID_SH_LSR};
            sh_amt  = {amount_fields == 5'h00, amount_fields};
          end
          `AID_SH_ASR: begin
            sh_kind = {1'b0, `AID_SH_ASR};
            sh_amt  = {amount_fields == 5'h00, amount_fields};
          end
          default: begin
            sh_kind = (amount_fields == 5'h00) ? `AID_SH_RRX :
                      {1'b0, `AID_SH_ROR};
            sh_amt  = (amount_fields == 5'h00) ? 6'h01 :
                      {1'b0, amount_fields};
          end
        endcase
        if (d_idx == `AID_R_PC && hw1[4])
          redir = `AID_RD_CMN_REG;
        else if (n_idx == `AID_R_SP)
          redir = `AID_RD_SP_REG;
        else if (!main_ext)
          undef = 1'b1;
        else if (d_idx == `AID_R_SP || (d_idx == `AID_R_PC && !hw1[4]) ||
                 n_idx == `AID_R_PC || m_idx == `AID_R_SP ||
                 m_idx == `AID_R_PC)
          unpred = 1'b1;
      end
    end
  end

  // Adder with carry in zero
  wire [31:0] pc_aligned = {pc_q[31:2], 2'h0};
  wire [31:0] src_n = src_val(n_idx, rf_q[n_idx], pc_q);
  wire [31:0] src_m = src_val(m_idx, rf_q[m_idx], pc_q);
  wire [31:0] op_a = use_pc ? pc_aligned : src_n;
  wire [31:0] op_b = use_imm ? imm32 :
                     shift_val(src_m, sh_kind, sh_amt,
                               flags_q[`AID_FLAG_C]);
  wire [32:0] sum  = {1'b0, op_a} + {1'b0, op_b};
  wire [31:0] res  = sum[31:0];
  wire        ovf  = (op_a[31] == op_b[31]) && (res[31] != op_a[31]);
  wire        commit = cond_ok && known && !undef && !unpred &&
                       redir == `AID_RD_NONE;

  // APB read decode
  wire        acc_setup = psel && !penable && !pready;
  wire        acc_done  = psel && penable && pready;
  wire        rf_hit    = paddr[7:6] == `AID_RF_BASE_HI && paddr[1:0] == 2'h0;
  reg  [31:0] rd_data;
  reg         rd_err;

  always @* begin
    rd_data = 32'h00000000;
    rd_err  = 1'b0;
    if (rf_hit) begin
      rd_data = rf_q[paddr[5:2]];
    end else begin
      case (paddr)
        `AID_OFF_INSTR:  rd_data = instr_q;
        `AID_OFF_PC:     rd_data = pc_q;
        `AID_OFF_CTRL:   rd_data = {27'h0000000, ctrl_q};
        `AID_OFF_CMD:    rd_data = {31'h00000000, go_q};
        `AID_OFF_FLAGS:  rd_data = {28'h0000000, flags_q};
        `AID_OFF_STATUS: rd_data = status_q;
        `AID_OFF_RESULT: rd_data = result_q;
        `AID_OFF_TARGET: rd_data = branch_addr_q;
        default:         rd_err  = 1'b1;
      endcase
    end
  end

  // APB response: no wait states, read data sampled in setup
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_setup;
      if (acc_setup) begin
        prdata  <= pwrite ? 32'h00000000 : rd_data;
        pslverr <= rd_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  wire wr_en = acc_done && pwrite && !rd_err;
  integer i;

  // Software registers and execution commit
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      instr_q        <= 32'h00000000;
      pc_q           <= 32'h00000000;
      ctrl_q         <= `AID_CTRL_RESET;
      flags_q        <= 4'h0;
      status_q       <= 32'h00000000;
      result_q       <= 32'h00000000;
      go_q           <= 1'b0;
      branch_valid_q <= 1'b0;
      branch_addr_q  <= 32'h00000000;
      for (i = 0; i < 16; i = i + 1)
        rf_q[i] <= 32'h00000000;
    end else begin
      go_q           <= wr_en && paddr == `AID_OFF_CMD &&
                        pwdata[`AID_CMD_GO];
      branch_valid_q <= 1'b0;
      if (wr_en) begin
        if (rf_hit)
          rf_q[paddr[5:2]] <= pwdata;
        else begin
          case (paddr)
            `AID_OFF_INSTR: instr_q <= pwdata;
            `AID_OFF_PC:    pc_q    <= pwdata;
            `AID_OFF_CTRL:  ctrl_q  <= pwdata[4:0];
            `AID_OFF_FLAGS: flags_q <= pwdata[3:0];
            default: ;
          endcase
        end
      end
      if (go_q) begin
        status_q <= {21'h000000, redir, 1'b0, !known,
                     commit && is_branch, redir != `AID_RD_NONE,
                     unpred, undef, commit, 1'b1};
        result_q <= use_pc ? pc_aligned + imm32 : res;
        if (commit) begin
          if (is_branch) begin
            pc_q           <= res;
            branch_valid_q <= 1'b1;
            branch_addr_q  <= res;
          end else begin
            rf_q[d_idx] <= res;
          end
          if (setflags && !use_pc) begin
            flags_q[`AID_FLAG_N] <= res[31];
            flags_q[`AID_FLAG_Z] <= res == 32'h00000000;
            flags_q[`AID_FLAG_C] <= sum[32];
            flags_q[`AID_FLAG_V] <= ovf;
          end
        end
      end
    end
  end

endmodule

// >>> testbench/aid_fetch_model.sv
module aid_fetch_model (
  // Clock and reset
  input  wire         clock,
  input  wire         rst_b,
  // Branch request from the block
  input  wire         branch_valid_q,
  input  wire  [31:0] branch_addr_q,
  // What fetch saw
  output logic [7:0]  taken_cnt,
  output logic [31:0] taken_addr
);
  timeunit 1ns;
  timeprecision 1ns;

  // Fetch redirects on every one-cycle request
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      taken_cnt  <= 8'h00;
      taken_addr <= 32'h0;
    end else if (branch_valid_q) begin
      taken_cnt  <= taken_cnt + 8'h01;
      taken_addr <= branch_addr_q;
    end
  end
endmodule

// >>> testbench/aid_add_exec_properties.sv
module aid_add_exec_props (
  // Clock and reset
  input wire        clock,
  input wire        rst_b,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Fetch side
  input wire        branch_valid_q,
  input wire [31:0] branch_addr_q
);
  timeunit 1ns;
  timeprecision 1ns;
  reg  [2:0] since_go_q;
  wire       go_wr;

  // Cycles since the last execute command was accepted
  assign go_wr = psel && penable && pready && pwrite
                 && paddr == 8'h0C && pwdata[0];
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      since_go_q <= 3'h7;
    else if (go_wr)
      since_go_q <= 3'h0;
    else if (since_go_q != 3'h7)
      since_go_q <= since_go_q + 3'h1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence

  chk_ready_setup: assert property (setup_s |=> access_s)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_ready_phase: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_wr_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  chk_err_map: assert property (pready |->
    pslverr == (paddr[7] || paddr[7:5] == 3'h1))
    else $error("error flag wrong for address");
  chk_branch_pulse: assert property (branch_valid_q |=> !branch_valid_q)
    else $error("branch request too long");
  chk_branch_cause: assert property (branch_valid_q |->
    since_go_q >= 3'h1 && since_go_q <= 3'h2)
    else $error("branch without execute");
  chk_target_hold: assert property ($changed(branch_addr_q) |-> branch_valid_q)
    else $error("target moved without branch");
endmodule

// >>> testbench/aid_add_exec_tb.sv
module aid_add_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Bus and fetch side
  logic        clock;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         branch_valid_q;
  wire  [31:0] branch_addr_q;
  wire  [7:0]  taken_cnt;
  wire  [31:0] taken_addr;
  logic [31:0] rd;
  logic        er;
  int          errors;
  int          checks;

  aid_add_exec uut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .branch_valid_q, .branch_addr_q);
  aid_fetch_model fetch (.clock, .rst_b, .branch_valid_q, .branch_addr_q,
    .taken_cnt, .taken_addr);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task test_done;
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task setr(input logic [3:0] n, input logic [31:0] v);
    wr({2'h1, n, 2'h0}, v);
  endtask

  task chkr(input logic [3:0] n, input logic [31:0] e);
    rdc("gpr", {2'h1, n, 2'h0}, e);
  endtask

  task exec(input logic [31:0] ins, input logic [7:0] ctl);
    wr(8'h00, ins);
    wr(8'h08, {24'h0, ctl});
    wr(8'h0C, 32'h1);
  endtask

  // Refused encodings: only the STATUS and RESULT registers may move
  task sts(input logic [31:0] ins, input logic [7:0] ctl,
           input logic [31:0] e);
    exec(ins, ctl);
    apb(1'b0, 8'h14, 32'h0);
    chk("status", e, rd & 32'h0000071E);
  endtask

  // Wide register add r3 = r1 + shifted r2
  task sh(input logic [1:0] t, input logic [4:0] a, input logic [31:0] e);
    exec({16'hEB01, 1'b0, a[4:2], 4'h3, a[1:0], t, 4'h2}, 8'h19);
    chkr(4'h3, e);
  endtask

  task t_imm;
    setr(4'h1, 32'hFFFFFF01);
    wr(8'h10, 32'h0);
    exec(32'h31FF, 8'h09);
    chkr(4'h1, 32'h0);
    rdc("flags", 8'h10, 32'h6);
    setr(4'h2, 32'h7FFFFFFF);
    exec(32'h1DD3, 8'h09);
    chkr(4'h3, 32'h80000006);
    rdc("flags", 8'h10, 32'h9);
  endtask

  task t_pc_wide;
    wr(8'h04, 32'h1002);
    exec(32'hA4FF, 8'h09);
    chkr(4'h4, 32'h13FC);
    setr(4'h5, 32'h1);
    wr(8'h10, 32'h5);
    exec(32'hF60576FF, 8'h19);
    chkr(4'h6, 32'h1000);
    rdc("flags", 8'h10, 32'h5);
  endtask

  // Wide modified-immediate forms and the wide aligned-PC add
  task t_modimm;
    setr(4'h5, 32'h1);
    wr(8'h10, 32'hF);
    exec(32'hF1151612, 8'h19);
    chkr(4'h6, 32'h00120013);
    rdc("flags", 8'h10, 32'h0);
    exec(32'hF5050780, 8'h19);
    chkr(4'h7, 32'h00400001);
    wr(8'h04, 32'h2003);
    exec(32'hF20F0810, 8'h19);
    chkr(4'h8, 32'h2010);
  endtask

  task t_regs;
    setr(4'h1, 32'h80000000);
    setr(4'h2, 32'h80000000);
    wr(8'h10, 32'h0);
    exec(32'h188F, 8'h0B);
    rdc("flags", 8'h10, 32'h0);
    exec(32'h188F, 8'h09);
    chkr(4'h7, 32'h0);
    rdc("flags", 8'h10, 32'h7);
    wr(8'h04, 32'h100);
    setr(4'hF, 32'h100);
    setr(4'h1, 32'h200);
    exec(32'h448F, 8'h09);
    rdc("pc", 8'h04, 32'h300);
    chk("target", 32'h300, taken_addr);
    chk("taken", 32'h1, {24'h0, taken_cnt});
    rdc("flags", 8'h10, 32'h7);
  endtask

  task t_refuse;
    sts(32'h4469, 8'h09, 32'h110);
    sts(32'h44FF, 8'h09, 32'h008);
    sts(32'h448F, 8'h0B, 32'h008);
    sts(32'hEB110F02, 8'h19, 32'h310);
    sts(32'hEB0D0302, 8'h19, 32'h110);
    sts(32'hEB010D02, 8'h19, 32'h008);
    sts(32'hEB01030F, 8'h19, 32'h008);
    sts(32'hEB010302, 8'h18, 32'h004);
    chkr(4'h3, 32'h80000006);
    sts(32'h31FF, 8'h01, 32'h000);
    chkr(4'h1, 32'h200);
  endtask

  task t_shift;
    setr(4'h1, 32'h10);
    setr(4'h2, 32'h80000001);
    wr(8'h10, 32'h2);
    sh(2'h0, 5'h01, 32'h12);
    sh(2'h1, 5'h00, 32'h10);
    sh(2'h2, 5'h02, 32'hE0000010);
    sh(2'h3, 5'h04, 32'h18000010);
    sh(2'h3, 5'h00, 32'hC0000010);
    rdc("flags", 8'h10, 32'h2);
    exec(32'hEB110302, 8'h19);
    chkr(4'h3, 32'h80000011);
    rdc("flags", 8'h10, 32'h8);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
  endtask

  initial begin
    #100000;
    errors++;
    test_done;
  end

  initial begin
    rst_b   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    t_imm;
    t_pc_wide;
    t_modimm;
    t_regs;
    t_refuse;
    t_shift;
    test_done;
  end
endmodule

bind aid_add_exec aid_add_exec_props chk (.clock, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .branch_valid_q,
  .branch_addr_q);
